// >>> include/rtcpin_pkg.sv
// constants for the rtc output pin control block
package rtcpin_pkg;
    // system clock rate
    localparam int unsigned CLK_HZ            = 25000000;
    // square wave rate and half period count
    localparam int unsigned WAVE_HZ           = 1;
    localparam int unsigned WAVE_HALF_CYC     = CLK_HZ / (2 * WAVE_HZ);
    // reset release delay after supply recovery, in ms (longest figure)
    localparam int unsigned REC_MS            = 250;
    localparam int unsigned REC_CYC           = (CLK_HZ / 1000) * REC_MS;
    // pushbutton debounce time in ms
    localparam int unsigned DEB_MS            = 10;
    localparam int unsigned DEB_CYC           = (CLK_HZ / 1000) * DEB_MS;
    // reset pulse length after a valid press, in ms
    localparam int unsigned PB_PULSE_MS       = 250;
    localparam int unsigned PB_PULSE_CYC      = (CLK_HZ / 1000) * PB_PULSE_MS;
    // control register address holding the select bit
    localparam logic [7:0]  CTRL_ADDR         = 8'h0e;
    // reset value of the interrupt select bit
    localparam logic        INT_SEL_RESET     = 1'b1;
    // counter width for all timers
    localparam int unsigned CNT_W             = 32;
    // reset pin controller states
    typedef enum logic [1:0] {
        RTCPIN_HOLD,
        RTCPIN_DELAY,
        RTCPIN_IDLE,
        RTCPIN_PULSE
    } rtcpin_state_t;
endpackage

// >>> logic/rtcpin_ctrl.sv
// output pin control: shared alarm/wave pin and open-drain reset pin
//
// Behaviour
// RULE1 - select bit picks shared pin function
// RULE2 - select zero gives 1Hz square wave
// RULE3 - select one drives low on alarm match
// RULE4 - power up: select one, alarms off (left to the register file; reset here only releases the shared pin)
// RULE5 - reset low while supply below threshold
// RULE6 - release delay after supply recovers, then float
// RULE7 - debounce pushbutton, pulse reset pin
// RULE8 - oscillator disabled skips release delay
// RULE9 - disable bit one means oscillator off
// RULE10 - reset pin never stalls interface or timekeeping
// RULE11 - square wave has half duty cycle
`timescale 1ns/1ps
module rtcpin_ctrl
    import rtcpin_pkg::*;
#(
    parameter int unsigned REC_CYCLES   = REC_CYC,
    parameter int unsigned DEB_CYCLES   = DEB_CYC,
    parameter int unsigned PULSE_CYCLES = PB_PULSE_CYC,
    parameter int unsigned HALF_CYCLES  = WAVE_HALF_CYC
)
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // control bits from the register file
    input  wire logic interrupt_select_bit,
    input  wire logic oscillator_disable_bit,
    input  wire logic alarm1_enable,
    input  wire logic alarm2_enable,
    // alarm match flags from the comparators
    input  wire logic alarm1_match,
    input  wire logic alarm2_match,
    // supply monitor: high while supply below power_fail_threshold
    input  wire logic supply_below_pf,
    // shared pin, open drain
    output logic      alarm_irq_or_wave_pin_o,
    output logic      alarm_irq_or_wave_pin_oe,
    // reset pin, open drain two-way
    input  wire logic reset_pin_n_i,
    output logic      reset_pin_n_o,
    output logic      reset_pin_oe,
    // status: device is driving reset low
    output logic      reset_active
);

    // refuse counts that are zero; the 32 bit counters hold any count given
    // every timer compares against count minus one, so a count of
    // zero would wrap to the all-ones value and never finish
    initial
    begin
        if (REC_CYCLES < 1 || DEB_CYCLES < 1 || PULSE_CYCLES < 1 ||
            HALF_CYCLES < 1)
            $error("rtcpin_ctrl: timer counts must be at least one");
    end

    logic [CNT_W-1:0] wave_cnt_r;     // square wave half period counter
    logic             wave_r;         // square wave level
    logic             irq_drive_r;    // registered shared pin pull-down
    logic [CNT_W-1:0] deb_cnt_r;      // debounce stability counter
    logic             pb_stable_r;    // debounced pin level
    logic [CNT_W-1:0] tmr_r;          // delay / pulse timer
    rtcpin_state_t    state_r;        // reset pin controller state
    rtcpin_state_t    state_nxt;
    logic [CNT_W-1:0] tmr_nxt;
    logic             drive_low_r;    // registered reset pin pull-down

    // decode of alarm and wave selection
    // the shared pin is open drain: a low level is made by raising the
    // output enable, a high level by releasing the pin to its pullup
    // alarm match flags are level inputs; the interrupt stays low for
    // as long as an enabled alarm matches, clearing is upstream
    wire  alarm_hit    = (alarm1_match & alarm1_enable) |
                         (alarm2_match & alarm2_enable);
    wire  wave_wrap    = (wave_cnt_r == CNT_W'(HALF_CYCLES - 1));
    // pin must stay low in wave mode when wave is low  [RULE1]
    wire  irq_nxt      = interrupt_select_bit ? alarm_hit     // [RULE3]
                                              : ~wave_r;      // [RULE2]
    // pin sampled differs from the debounced level
    wire  pb_differs   = (reset_pin_n_i != pb_stable_r);
    wire  deb_done     = (deb_cnt_r == CNT_W'(DEB_CYCLES - 1));
    // debounced falling edge while we are not driving: a press
    wire  pb_press     = pb_differs & deb_done & pb_stable_r &
                         ~drive_low_r;
    // oscillator off bypasses the delay  [RULE9]
    wire  osc_off      = oscillator_disable_bit;

    // free running divider; runs whatever the reset pin does  [RULE10]
    // the divider also runs in alarm mode, so a switch to wave mode
    // may start with a short first half; later halves are all equal
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            wave_cnt_r <= '0;
            wave_r     <= 1'b0;
        end
        else if (wave_wrap)
        begin
            wave_cnt_r <= '0;
            wave_r     <= ~wave_r;    // equal halves  [RULE11]
        end
        else
            wave_cnt_r <= wave_cnt_r + CNT_W'(1);
    end

    // shared pin register; reset leaves it released, the select
    // bit default of one and alarms off are the register file's job
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            irq_drive_r <= 1'b0;     // idle interrupt output  [RULE4]
        else
            irq_drive_r <= irq_nxt;
    end

    assign alarm_irq_or_wave_pin_o  = 1'b0;
    assign alarm_irq_or_wave_pin_oe = irq_drive_r;

    // pushbutton debounce: level must hold for the whole window
    // any return to the stable level restarts the window, so bounce
    // shorter than the window is ignored entirely
    // our own pull-down also shows on the sensed pin; the press
    // decode masks it so a pulse never triggers a second pulse
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            deb_cnt_r   <= '0;
            pb_stable_r <= 1'b1;
        end
        else if (!pb_differs)
            deb_cnt_r   <= '0;
        else if (deb_done)
        begin
            deb_cnt_r   <= '0;
            pb_stable_r <= reset_pin_n_i;   // [RULE7]
        end
        else
            deb_cnt_r   <= deb_cnt_r + CNT_W'(1);
    end

    // reset pin controller next state
    // supply failure always wins: from any state a low supply returns
    // to hold, so a press pulse cannot mask a power-fail indication
    // the release delay counts from the first edge the supply is good
    always_comb
    begin
        state_nxt = state_r;
        tmr_nxt   = tmr_r;
        case (state_r)
            RTCPIN_HOLD:
            begin
                tmr_nxt = '0;
                if (!supply_below_pf)
                    state_nxt = osc_off ? RTCPIN_IDLE      // [RULE8]
                                        : RTCPIN_DELAY;    // [RULE6]
            end
            RTCPIN_DELAY:
            begin
                tmr_nxt = tmr_r + CNT_W'(1);
                if (supply_below_pf)
                    state_nxt = RTCPIN_HOLD;               // [RULE5]
                else if (osc_off ||
                         tmr_r == CNT_W'(REC_CYCLES - 1))
                    state_nxt = RTCPIN_IDLE;               // [RULE6]
            end
            RTCPIN_IDLE:
            begin
                tmr_nxt = '0;
                if (supply_below_pf)
                    state_nxt = RTCPIN_HOLD;               // [RULE5]
                else if (pb_press)
                    state_nxt = RTCPIN_PULSE;              // [RULE7]
            end
            RTCPIN_PULSE:
            begin
                tmr_nxt = tmr_r + CNT_W'(1);
                if (supply_below_pf)
                    state_nxt = RTCPIN_HOLD;
                else if (tmr_r == CNT_W'(PULSE_CYCLES - 1))
                    state_nxt = RTCPIN_IDLE;
            end
            default:
            begin
                state_nxt = RTCPIN_HOLD;
                tmr_nxt   = '0;
            end
        endcase
    end

    // reset pin controller registers; starts holding reset low
    // the pull-down is registered from the next state so the pin
    // changes on the same edge as the state, with no decode glitch
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_r     <= RTCPIN_HOLD;
            tmr_r       <= '0;
            drive_low_r <= 1'b1;
        end
        else
        begin
            state_r     <= state_nxt;
            tmr_r       <= tmr_nxt;
            drive_low_r <= (state_nxt != RTCPIN_IDLE);   // [RULE5]
        end
    end

    // open drain: only ever pulls low, pullup raises the line
    // the status output mirrors the pull-down, not the sensed pin, so
    // an external request does not show as a device reset
    assign reset_pin_n_o = 1'b0;
    assign reset_pin_oe  = drive_low_r;
    assign reset_active  = drive_low_r;

endmodule

// >>> test/rtcpin_ctrl_assertions.sv
// timing checks on the pin control ports
`timescale 1ns/1ps
module rtcpin_ctrl_assertions (
    // watched ports
    input wire logic sys_clk, rst, interrupt_select_bit,
    input wire logic oscillator_disable_bit, supply_below_pf,
    input wire logic alarm1_enable, alarm2_enable,
    input wire logic alarm1_match, alarm2_match,
    input wire logic alarm_irq_or_wave_pin_o, alarm_irq_or_wave_pin_oe,
    input wire logic reset_pin_n_o, reset_pin_oe, reset_active
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    // any enabled alarm that matches
    wire hit = (alarm1_enable & alarm1_match) | (alarm2_enable & alarm2_match);
    property p_od; !alarm_irq_or_wave_pin_o && !reset_pin_n_o; endproperty
    property p_irq; interrupt_select_bit && hit |=> alarm_irq_or_wave_pin_oe;
    endproperty
    property p_quiet; interrupt_select_bit && !hit |=> !alarm_irq_or_wave_pin_oe;
    endproperty
    // tb runs the wave with five cycle halves
    // mode must have been wave for two samples, else a half is cut short
    property p_wave; !interrupt_select_bit && !$past(interrupt_select_bit) &&
        !$past(interrupt_select_bit, 2) && $rose(alarm_irq_or_wave_pin_oe)
        |-> alarm_irq_or_wave_pin_oe[*5]; endproperty
    property p_pf; supply_below_pf[*3] |-> reset_pin_oe; endproperty
    // bounds follow the bench release delay of 20
    property p_rec; $fell(supply_below_pf) && !oscillator_disable_bit
        |-> reset_pin_oe[*8] ##[10:16] !reset_pin_oe; endproperty
    property p_byp; $fell(supply_below_pf) && oscillator_disable_bit
        |-> ##[1:2] !reset_pin_oe; endproperty
    property p_act; reset_active == reset_pin_oe; endproperty
    a_od: assert property (p_od) else $error("pin data not low");
    a_irq: assert property (p_irq) else $error("alarm missed");
    a_quiet: assert property (p_quiet) else $error("spurious irq");
    a_wave: assert property (p_wave) else $error("bad half");
    a_pf: assert property (p_pf) else $error("reset not held");
    a_rec: assert property (p_rec) else $error("bad release");
    a_byp: assert property (p_byp) else $error("no bypass");
    a_act: assert property (p_act) else $error("status differs");
    c_irq: cover property (interrupt_select_bit && hit);
    c_wave: cover property ($fell(alarm_irq_or_wave_pin_oe));
    c_press: cover property ($rose(reset_pin_oe) && !supply_below_pf);
endmodule
bind rtcpin_ctrl rtcpin_ctrl_assertions rtcpin_ctrl_assertions_i (.*);

// >>> test/rtcpin_host.sv
// host side model: pushbutton on the reset wire
`timescale 1ns/1ps
module rtcpin_host (
    // clock and button request
    input  wire logic sys_clk,
    input  wire logic press,
    // pulls the wire low, open drain
    output logic      pull_low
);
    initial pull_low = 1'b0;
    // button follows the request on the rising edge, after the design
    // has sampled, so it never races the bench's falling-edge drive
    always @(posedge sys_clk)
        pull_low <= press;
endmodule

// >>> test/rtcpin_ctrl_tb.sv
// testbench for the rtc pin control block
`timescale 1ns/1ps
module rtcpin_ctrl_tb;
    logic sys_clk = 0, rst = 1, isb = 1, odb = 0, a1e = 0, a2e = 0;
    logic a1m = 0, a2m = 0, sbp = 1, press = 0, pull_low;
    logic irq_o, irq_oe, rst_o, rst_oe, ract;
    int   error_cnt = 0, num_checks = 0;
    // pullups on both open drain wires
    wire  irq_pin = ~irq_oe;
    wire  rpin = ~(rst_oe | pull_low);
    rtcpin_ctrl #(.REC_CYCLES(20), .DEB_CYCLES(4), .PULSE_CYCLES(10),
        .HALF_CYCLES(5)) rtcpin_ctrl_i (.sys_clk(sys_clk), .rst(rst),
        .interrupt_select_bit(isb), .oscillator_disable_bit(odb),
        .alarm1_enable(a1e), .alarm2_enable(a2e), .alarm1_match(a1m),
        .alarm2_match(a2m), .supply_below_pf(sbp),
        .alarm_irq_or_wave_pin_o(irq_o), .alarm_irq_or_wave_pin_oe(irq_oe),
        .reset_pin_n_i(rpin), .reset_pin_n_o(rst_o), .reset_pin_oe(rst_oe),
        .reset_active(ract));
    rtcpin_host rtcpin_host_i (.sys_clk(sys_clk), .press(press),
        .pull_low(pull_low));
    initial forever #20 sys_clk = ~sys_clk;
    task tally_and_finish;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // cycles until the chosen enable leaves level v, bounded
    task span(input bit w, input logic v, output int n);
        n = 0;
        do @(negedge sys_clk); while ((w ? irq_oe : rst_oe) === v && ++n < 200);
        n++;
        if (n >= 200)
        begin
            error_cnt++;
            tally_and_finish();
        end
    endtask
    task t_power(output int n);
        chk("hold", rst_oe, 1);
        chk("idle", irq_pin, 1);
        sbp = 0;
        span(0, 1, n);
        chk("rec", n > 20 && n < 24, 1);
        $display("power done");
    endtask
    task t_alarm;
        for (int i = 0; i < 16; i++)
        begin
            {a1e, a2e, a1m, a2m} = i[3:0];
            repeat (2) @(negedge sys_clk);
            chk("irq", irq_pin, !(i[3] & i[1] | i[2] & i[0]));
        end
        $display("alarm done");
    endtask
    task t_wave(output int n);
        isb = 0;
        span(1, 1, n);
        span(1, 0, n);
        span(1, 1, n);
        chk("high", n, 5);
        span(1, 0, n);
        chk("low", n, 5);
        isb = 1;
        $display("wave done");
    endtask
    task t_press(output int n);
        press = 1;
        span(0, 0, n);
        chk("deb", n > 3 && n < 8, 1);
        repeat (3) @(negedge sys_clk);
        press = 0;
        span(0, 1, n);
        chk("pulse", n > 5 && n < 11, 1);
        repeat (10) @(negedge sys_clk);
        $display("press done");
    endtask
    task t_bypass;
        {odb, sbp, a1e, a1m} = 4'hf;
        repeat (3) @(negedge sys_clk);
        chk("pf", rst_oe, 1);
        chk("live", irq_pin, 0);
        chk("act", ract, 1);
        chk("od", {irq_o, rst_o}, 0);
        sbp = 0;
        repeat (3) @(negedge sys_clk);
        chk("byp", rst_oe, 0);
        $display("bypass done");
    endtask
    initial
    begin
        int n;
        repeat (3) @(negedge sys_clk);
        rst = 0;
        repeat (3) @(negedge sys_clk);
        t_power(n);
        t_alarm();
        t_wave(n);
        t_press(n);
        t_bypass();
        tally_and_finish();
    end
endmodule
